// ### include/iep_pkg.sv
package iep_pkg;
	localparam logic [7:0] IEP_ADDR_PRIO2_LO = 8'h91;
	localparam logic [7:0] IEP_ADDR_PRIO2_HI = 8'h92;
	localparam logic [7:0] IEP_ADDR_EN1 = 8'hA8;
	localparam logic [7:0] IEP_ADDR_PRIO1_HI = 8'hB7;
	localparam logic [7:0] IEP_ADDR_PRIO1_LO = 8'hB8;
	localparam logic [7:0] IEP_ADDR_EN2 = 8'hE8;
	localparam logic [7:0] IEP_RESET_VAL = 8'h00;
	localparam int IEP_GLOBAL_BIT = 7;
	localparam int IEP_NSRC = 10;
	localparam logic [7:0] IEP_EN2_MASK = 8'h07;
	localparam logic [7:0] IEP_PRIO2_MASK = 8'h03;
	// Source index: first byte bits 0..6 as the first enable register,
	// timer 2 = 7, secondary two-wire = 8, sync serial = 9
	localparam logic [3:0] IEP_SRC_EXT0 = 4'h0;
	localparam logic [3:0] IEP_SRC_TMR0 = 4'h1;
	localparam logic [3:0] IEP_SRC_EXT1 = 4'h2;
	localparam logic [3:0] IEP_SRC_TMR1 = 4'h3;
	localparam logic [3:0] IEP_SRC_SER = 4'h4;
	localparam logic [3:0] IEP_SRC_TW1 = 4'h5;
	localparam logic [3:0] IEP_SRC_CNT = 4'h6;
	localparam logic [3:0] IEP_SRC_TMR2 = 4'h7;
	localparam logic [3:0] IEP_SRC_TW2 = 4'h8;
	localparam logic [3:0] IEP_SRC_SSI = 4'h9;

	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iep_sfr_req_s;

	typedef struct packed {
		logic valid;
		logic [3:0] src;
		logic [1:0] level;
	} iep_irq_s;
endpackage

// ### hw/iep_regs.sv
`timescale 1ns/1ns
`default_nettype none
module iep_regs
	import iep_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Special-function register access from the core
	input wire iep_pkg::iep_sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Interrupt sources and service status
	input wire logic [9:0] src_pending,
	input wire logic [1:0] active_level,
	input wire logic any_active,
	// Request to the core
	output iep_pkg::iep_irq_s irq_out
);
	logic [7:0] en1_reg;
	logic [7:0] en2_reg;
	logic [7:0] plo1_reg;
	logic [7:0] phi1_reg;
	logic [7:0] plo2_reg;
	logic [7:0] phi2_reg;
	logic [9:0] allow;
	logic [9:0] plo;
	logic [9:0] phi;
	iep_irq_s irq_next;
	logic [7:0] rd_next;
	logic hit_next;

	// Bit ops merge one bit into the held byte; others pass the byte
	function automatic logic [7:0] merge(input logic [7:0] cur,
		input iep_sfr_req_s rq);
		logic [7:0] v;
		v = cur;
		if (rq.bit_op) begin
			v[rq.bit_sel] = rq.wdata[0];
		end else begin
			v = rq.wdata;
		end
		return v;
	endfunction

	function automatic logic wr_at(input iep_sfr_req_s rq,
		input logic [7:0] a);
		return rq.wr && (rq.addr == a);
	endfunction

	always_ff @(posedge mclk) begin
		if (rst) begin
			en1_reg <= IEP_RESET_VAL;
		end else if (wr_at(sfr_req, IEP_ADDR_EN1)) begin
			en1_reg <= merge(en1_reg, sfr_req);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			en2_reg <= IEP_RESET_VAL;
		end else if (wr_at(sfr_req, IEP_ADDR_EN2)) begin
			// Reserved bits kept zero so a stray set never reads back
			en2_reg <= merge(en2_reg, sfr_req) & IEP_EN2_MASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			plo1_reg <= IEP_RESET_VAL;
		end else if (wr_at(sfr_req, IEP_ADDR_PRIO1_LO)) begin
			plo1_reg <= merge(plo1_reg, sfr_req);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			plo2_reg <= IEP_RESET_VAL;
		end else if (wr_at(sfr_req, IEP_ADDR_PRIO2_LO)) begin
			plo2_reg <= merge(plo2_reg, sfr_req) & IEP_PRIO2_MASK;
		end
	end

	// High priority registers ignore bit ops: not bit addressable
	always_ff @(posedge mclk) begin
		if (rst) begin
			phi1_reg <= IEP_RESET_VAL;
		end else if (wr_at(sfr_req, IEP_ADDR_PRIO1_HI) && !sfr_req.bit_op) begin
			phi1_reg <= sfr_req.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			phi2_reg <= IEP_RESET_VAL;
		end else if (wr_at(sfr_req, IEP_ADDR_PRIO2_HI) && !sfr_req.bit_op) begin
			phi2_reg <= sfr_req.wdata & IEP_PRIO2_MASK;
		end
	end

	always_comb begin
		rd_next = 8'h00;
		hit_next = 1'b1;
		case (sfr_req.addr)
			IEP_ADDR_EN1: rd_next = en1_reg;
			IEP_ADDR_EN2: rd_next = en2_reg;
			IEP_ADDR_PRIO1_LO: rd_next = plo1_reg;
			IEP_ADDR_PRIO1_HI: rd_next = phi1_reg;
			IEP_ADDR_PRIO2_LO: rd_next = plo2_reg;
			IEP_ADDR_PRIO2_HI: rd_next = phi2_reg;
			default: hit_next = 1'b0;
		endcase
		if (!sfr_req.rd) begin
			hit_next = 1'b0;
			rd_next = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
			sfr_hit <= 1'b0;
		end else begin
			sfr_rdata <= rd_next;
			sfr_hit <= hit_next;
		end
	end

	// Index layout: bits 0..6 match the first enable register
	assign allow = {en2_reg[2:0], en1_reg[6:0]};
	assign plo = {plo2_reg[1:0], plo1_reg[7:0]};
	assign phi = {phi2_reg[1:0], phi1_reg[7:0]};

	// Fixed polling order at equal level, first wins
	localparam logic [3:0] POLL [IEP_NSRC] = '{IEP_SRC_EXT0, IEP_SRC_TW1,
		IEP_SRC_TMR0, IEP_SRC_EXT1, IEP_SRC_TMR1, IEP_SRC_SER,
		IEP_SRC_TMR2, IEP_SRC_CNT, IEP_SRC_SSI, IEP_SRC_TW2};

	always_comb begin
		logic [1:0] lvl;
		logic [3:0] s;
		irq_next = '0;
		lvl = 2'h0;
		s = 4'h0;
		if (en1_reg[IEP_GLOBAL_BIT]) begin
			for (int i = 0; i < IEP_NSRC; i++) begin
				s = POLL[i];
				lvl = {phi[s], plo[s]};
				// Strictly higher level wins; equal keeps poll order
				if (src_pending[s] && allow[s] &&
					(!irq_next.valid || lvl > irq_next.level)) begin
					irq_next.valid = 1'b1;
					irq_next.src = s;
					irq_next.level = lvl;
				end
			end
			// Only a strictly higher level may preempt running service
			if (any_active && irq_next.level <= active_level) begin
				irq_next = '0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_out <= '0;
		end else begin
			irq_out <= irq_next;
		end
	end
endmodule
`default_nettype wire

// ### sim/iep_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module iep_regs_assertions
	import iep_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register access
	input wire iep_pkg::iep_sfr_req_s sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	// Sources and request
	input wire logic [9:0] src_pending,
	input wire logic [1:0] active_level,
	input wire logic any_active,
	input wire iep_pkg::iep_irq_s irq_out
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	logic map;
	assign map = sfr_req.addr inside {8'h91, 8'h92, 8'hA8, 8'hB7, 8'hB8, 8'hE8};
	sequence rd_s(a);
		sfr_req.rd && sfr_req.addr == a;
	endsequence
	chk_mapped_hit: assert property (sfr_req.rd && map |=> sfr_hit)
		else $error("mapped read gave no hit");
	chk_en2_resv: assert property (rd_s(8'hE8) |=> !sfr_rdata[7:3])
		else $error("reserved enable bits set");
	chk_prio2_resv: assert property (
		(rd_s(8'h91) or rd_s(8'h92)) |=> !sfr_rdata[7:2])
		else $error("reserved priority bits set");
	chk_no_pending: assert property (!src_pending |=> !irq_out.valid)
		else $error("request without pending source");
	chk_top_active: assert property (any_active && active_level == 2'h3
		|=> !irq_out.valid) else $error("top level service interrupted");
	chk_src_pending: assert property (irq_out.valid
		|-> |($past(src_pending) & (10'h1 << irq_out.src)))
		else $error("granted source was not pending");
	chk_level_beats: assert property (irq_out.valid && $past(any_active)
		|-> irq_out.level > $past(active_level)) else $error("no preemption");
	chk_quiet_rst: assert property ($fell(rst) |-> !irq_out.valid)
		else $error("request right after reset");
endmodule
bind iep_regs iep_regs_assertions u_chk(.mclk(mclk), .rst(rst),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
	.src_pending(src_pending), .active_level(active_level),
	.any_active(any_active), .irq_out(irq_out));
`default_nettype wire

// ### sim/iep_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module iep_core_model (
	// Stimulus word from the bench
	input wire logic [12:0] cmd,
	// Pending sources and service status
	output logic [9:0] src_pending,
	output logic [1:0] active_level,
	output logic any_active
);
	// Flags are levels held until the bench changes them, as real sources do
	assign {any_active, active_level, src_pending} = cmd;
endmodule
`default_nettype wire

// ### sim/interrupt_enable_priority_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module interrupt_enable_priority_regs_test;
	import iep_pkg::*;
	logic mclk = 0, rst = 1, hit, act;
	iep_sfr_req_s req = '0;
	logic [7:0] rdat, v[6], q[$];
	logic [7:0] ad[6] = '{8'hA8, 8'hE8, 8'hB8, 8'hB7, 8'h91, 8'h92};
	logic [7:0] mk[6] = '{8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h03, 8'h03};
	logic [12:0] cmd = '0;
	logic [9:0] pend;
	logic [1:0] al;
	iep_irq_s irq;
	int n_fail = 0, samples_checked = 0, seed = 32'h4cd4, i, k;
	always #10 mclk = ~mclk;
	iep_regs u_dut(.mclk(mclk), .rst(rst), .sfr_req(req), .sfr_rdata(rdat),
		.sfr_hit(hit), .src_pending(pend), .active_level(al),
		.any_active(act), .irq_out(irq));
	iep_core_model u_core(.cmd(cmd), .src_pending(pend), .active_level(al),
		.any_active(act));
	task chk(input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task end_sim;
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One access, then an idle edge so strobes never merge
	task acc(input logic [21:0] r);
		req <= r;
		@(posedge mclk);
		req <= '0;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a, e);
		q.push_back(e);
		acc({3'b010, 3'h0, a, 8'h00});
	endtask
	// Arbitration reference: first in poll order wins a tie
	function logic [7:0] ex;
		logic [9:0] en, lo, hi;
		logic [3:0] s, o[10];
		logic [2:0] b;
		en = {v[1][2:0], v[0][6:0]};
		lo = {v[4][1:0], v[2]};
		hi = {v[5][1:0], v[3]};
		o = '{0, 5, 1, 2, 3, 4, 7, 6, 9, 8};
		b = 0;
		s = 0;
		for (int j = 0; j < 10; j++)
			if (pend[o[j]] && en[o[j]] && {1'b1, hi[o[j]], lo[o[j]]} > b) begin
				b = {1'b1, hi[o[j]], lo[o[j]]};
				s = o[j];
			end
		if (!v[0][7] || !b[2] || act && b[1:0] <= al)
			return 8'h00;
		return {1'b0, 1'b1, s, b[1:0]};
	endfunction
	always @(posedge mclk) begin
		if (hit === 1'b1) begin
			// A hit with nothing expected means an unmapped read answered
			chk(8'(q.size() != 0), 8'h01);
			if (q.size() != 0)
				chk(rdat, q.pop_front());
		end
	end
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		for (i = 0; i < 6; i++)
			rd(ad[i], 8'h00);
		for (i = 0; i < 6; i++) begin
			acc({3'b100, 3'h0, ad[i], 8'hFF});
			rd(ad[i], mk[i]);
		end
		acc({3'b101, 3'h0, 8'hA8, 8'h00});
		rd(8'hA8, 8'hFE);
		acc({3'b101, 3'h0, 8'hB7, 8'h00});
		rd(8'hB7, 8'hFF);
		acc({3'b010, 3'h0, 8'h00, 8'h00});
		repeat (40) begin
			for (k = 0; k < 6; k++) begin
				v[k] = 8'($random(seed)) & mk[k];
				acc({3'b100, 3'h0, ad[k], v[k]});
			end
			cmd <= 13'($random(seed));
			repeat (2) @(posedge mclk);
			chk({1'b0, irq.valid ? irq : 7'h0}, ex());
		end
		chk(8'(q.size()), 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
